/* design/phy_ext_regs.sv */
// Purpose: Extended page 1 mode, power-save, downshift, inline power and
//          CRC error registers of the copper PHY core.
// Assumes: The management frame decoder hands over one register access at
//          a time as a one-cycle read or write strobe with a 5-bit address.
// Notes:   Address 31 is the page selector and is held here as well.
`include "phy_ext_map.svh"
`timescale 1ns/1ns
`default_nettype none
module phy_ext_regs
  import phy_ext_pkg::*;
#(
  parameter int CRC_WIDTH = 8,
  parameter logic [31:0] SLEEP_UNIT_CYC = `SLEEP_UNIT_CYC,
  parameter logic [31:0] WAKE_0_CYC = `WAKE_0_CYC,
  parameter logic [31:0] WAKE_1_CYC = `WAKE_1_CYC,
  parameter logic [31:0] WAKE_2_CYC = `WAKE_2_CYC,
  parameter logic [31:0] WAKE_3_CYC = `WAKE_3_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_we,
  input wire logic mgmt_re,
  output logic [15:0] mgmt_rdata_q,
  output logic mgmt_rvalid_q,
  input wire logic chip_hold_mode,
  input wire logic [4:0] phy_addr_strap,
  input wire logic copper_selected,
  input wire logic link_idle,
  input wire logic link_up,
  input wire logic giga_neg_fail,
  input wire logic [1:0] inline_power_found,
  input wire logic crc_error,
  output logic indicator_output_a_ext_q,
  output logic indicator_output_b_ext_q,
  output logic indicator_blink_q,
  output logic flf_pin_en_q,
  output logic auto_xover_q,
  output logic crossed_wiring_q,
  output logic carrier_ext_dis_q,
  output logic slow_mgmt_clock_q,
  output logic rx_no_preamble_q,
  output logic power_save_sleep_q,
  output logic wake_probe_q,
  output logic downshift_q,
  output logic inline_power_det_en_q
);
  if (CRC_WIDTH < 1 || CRC_WIDTH > 8) begin : g_chk_crc
    $error("phy_ext_regs: CRC_WIDTH must lie in 1..8");
  end
  if (SLEEP_UNIT_CYC == 0 || WAKE_0_CYC == 0) begin : g_chk_time
    $error("phy_ext_regs: timer counts must be nonzero");
  end

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Idle interval before sleep: one to four units.
  function automatic logic [31:0] sleep_limit(input logic [1:0] sel);
    sleep_limit = SLEEP_UNIT_CYC * 32'(sel + 2'd0) + SLEEP_UNIT_CYC;
  endfunction

  // Interval between wake-up probes while asleep.
  function automatic logic [31:0] wake_limit(input logic [1:0] sel);
    case (sel)
      2'h0: wake_limit = WAKE_0_CYC;
      2'h1: wake_limit = WAKE_1_CYC;
      2'h2: wake_limit = WAKE_2_CYC;
      default: wake_limit = WAKE_3_CYC;
    endcase
  endfunction

  // Failed gigabit attempts that call for a downshift: two to five.
  function automatic logic [2:0] ds_limit(input logic [1:0] sel);
    ds_limit = {1'b0, sel} + 3'h2;
  endfunction

  // ****************************************************************
  // Register storage and access decode
  // ****************************************************************
  reg_word_t page_q;
  reg_word_t em_q;
  reg_word_t pd_q;
  reg_word_t ic_q;
  logic [4:0] addr_q;
  logic strap_taken_q;
  logic page1;
  logic wr_em;
  logic wr_pd;
  logic wr_ic;
  logic rd_crc;
  logic [CRC_WIDTH-1:0] crc_count;
  logic ds_status_q;
  logic hold_d1_q;

  // Page one must be selected before addresses 19, 20 and 23 map here.
  assign page1 = (page_q == `PAGE_EXT1);
  assign wr_em = mgmt_we && page1 && mgmt_addr == `ADDR_EXT_MODE;
  assign wr_pd = mgmt_we && page1 && mgmt_addr == `ADDR_PWR_DOWN;
  assign wr_ic = mgmt_we && page1 && mgmt_addr == `ADDR_INL_CRC;
  assign rd_crc = mgmt_re && page1 && mgmt_addr == `ADDR_INL_CRC;

  // Page selector takes every write to address 31, whatever the page.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      page_q <= `PAGE_MAIN;
    end else if (mgmt_we && mgmt_addr == `ADDR_PAGE_SEL) begin
      page_q <= mgmt_wdata;
    end
  end

  // Writable bits only; reserved and status bits never store.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      em_q <= `EM_RESET;
      pd_q <= `PD_RESET;
      ic_q <= `IC_RESET;
    end else begin
      if (wr_em) begin
        em_q <= mgmt_wdata & `EM_WMASK;
      end
      if (wr_pd) begin
        pd_q <= mgmt_wdata & `PD_WMASK;
      end
      if (wr_ic) begin
        ic_q <= mgmt_wdata & `IC_WMASK;
      end
    end
  end

  // The address straps are caught on the first clock after reset release,
  // since a reset flop may only load a constant.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      addr_q <= 5'h00;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      addr_q <= phy_addr_strap;
      strap_taken_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg_word_t rd_word;

  // Status fields are merged at read time; reserved bits stay zero.
  always_comb begin
    rd_word = 16'h0000;
    if (mgmt_addr == `ADDR_PAGE_SEL) begin
      rd_word = page_q;
    end else if (page1) begin
      case (mgmt_addr)
        `ADDR_EXT_MODE: rd_word = em_q;
        `ADDR_PWR_DOWN: begin
          rd_word = pd_q;
          rd_word[`PD_MEDIA_HI:`PD_MEDIA_LO] =
            copper_selected ? 2'h1 : 2'h0;
          rd_word[`PD_DS_STAT] = ds_status_q;
        end
        `ADDR_INL_CRC: begin
          rd_word = ic_q;
          rd_word[`IC_ADDR_HI:`IC_ADDR_LO] = addr_q;
          // Detection status only counts while detection is on.
          if (ic_q[`IC_INL_EN]) begin
            rd_word[`IC_INL_HI:`IC_INL_LO] =
              inline_power_found;
          end
          rd_word[CRC_WIDTH-1:0] = crc_count;
        end
        default: rd_word = 16'h0000;
      endcase
    end
  end

  // Read data comes one cycle after the strobe with a valid pulse.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mgmt_rdata_q <= 16'h0000;
      mgmt_rvalid_q <= 1'b0;
    end else begin
      mgmt_rvalid_q <= mgmt_re;
      if (mgmt_re) begin
        mgmt_rdata_q <= rd_word;
      end
    end
  end

  // ****************************************************************
  // CRC error counter
  // ****************************************************************
  crc_err_counter #(
    .WIDTH(CRC_WIDTH)
  ) u_crc (
    .clock(clock),
    .rstn(rstn),
    .inc(crc_error),
    .clr(rd_crc),
    .count_q(crc_count)
  );

  // ****************************************************************
  // Mode outputs
  // ****************************************************************

  // Straight copies of control bits, registered for clean timing.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      indicator_output_a_ext_q <= 1'b0;
      indicator_output_b_ext_q <= 1'b0;
      flf_pin_en_q <= 1'b1;
      carrier_ext_dis_q <= 1'b1;
      slow_mgmt_clock_q <= 1'b0;
      rx_no_preamble_q <= 1'b0;
      inline_power_det_en_q <= 1'b0;
    end else begin
      indicator_output_a_ext_q <= em_q[`EM_IND_A_EXT];
      indicator_output_b_ext_q <= em_q[`EM_IND_B_EXT];
      flf_pin_en_q <= em_q[`EM_FLF];
      carrier_ext_dis_q <= pd_q[`PD_CEXT_DIS];
      slow_mgmt_clock_q <= pd_q[`PD_SLOW_MC];
      rx_no_preamble_q <= pd_q[`PD_NO_PRE];
      inline_power_det_en_q <= ic_q[`IC_INL_EN];
    end
  end

  // Reserved code 01 falls back to automatic crossover, the safe choice.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      auto_xover_q <= 1'b1;
      crossed_wiring_q <= 1'b0;
    end else begin
      auto_xover_q <= !em_q[`EM_XOVER_HI];
      crossed_wiring_q <= em_q[`EM_XOVER_HI] && em_q[`EM_XOVER_LO];
    end
  end

  // One blink request on leaving chip hold, unless suppressed.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      hold_d1_q <= 1'b0;
      indicator_blink_q <= 1'b0;
    end else begin
      hold_d1_q <= chip_hold_mode;
      indicator_blink_q <= hold_d1_q && !chip_hold_mode
                           && em_q[`EM_BLINK];
    end
  end

  // ****************************************************************
  // Power-save sequencer
  // ****************************************************************
  ps_state_e ps_q;
  logic [31:0] ps_cnt_q;

  // Idle time counts toward sleep; asleep, wake probes repeat until the
  // link shows energy. A changed setting takes effect on the next compare.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ps_q <= PS_AWAKE;
      ps_cnt_q <= 32'h0000_0000;
      power_save_sleep_q <= 1'b0;
      wake_probe_q <= 1'b0;
    end else begin
      wake_probe_q <= 1'b0;
      case (ps_q)
        PS_AWAKE: begin
          if (!link_idle) begin
            ps_cnt_q <= 32'h0000_0000;
          end else if (ps_cnt_q + 32'h1 >=
                       sleep_limit(pd_q[`PD_SLEEP_HI:`PD_SLEEP_LO])) begin
            ps_q <= PS_SLEEP;
            ps_cnt_q <= 32'h0000_0000;
            power_save_sleep_q <= 1'b1;
          end else begin
            ps_cnt_q <= ps_cnt_q + 32'h1;
          end
        end
        PS_SLEEP: begin
          if (!link_idle) begin
            ps_q <= PS_AWAKE;
            ps_cnt_q <= 32'h0000_0000;
            power_save_sleep_q <= 1'b0;
          end else if (ps_cnt_q + 32'h1 >=
                       wake_limit(pd_q[`PD_WAKE_HI:`PD_WAKE_LO])) begin
            ps_cnt_q <= 32'h0000_0000;
            wake_probe_q <= 1'b1;
          end else begin
            ps_cnt_q <= ps_cnt_q + 32'h1;
          end
        end
        default: begin
          ps_q <= PS_AWAKE;
          ps_cnt_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Speed downshift
  // ****************************************************************
  logic [2:0] fail_cnt_q;

  // Failures count while enabled; link up restarts the count. The status
  // stays set once reached, until the feature is switched off.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      fail_cnt_q <= 3'h0;
      ds_status_q <= 1'b0;
      downshift_q <= 1'b0;
    end else begin
      if (!pd_q[`PD_DS_EN]) begin
        fail_cnt_q <= 3'h0;
        ds_status_q <= 1'b0;
      end else begin
        if (link_up) begin
          fail_cnt_q <= 3'h0;
        end else if (giga_neg_fail && fail_cnt_q != 3'h7) begin
          fail_cnt_q <= fail_cnt_q + 3'h1;
        end
        if (fail_cnt_q >= ds_limit(pd_q[`PD_DS_CNT_HI:`PD_DS_CNT_LO])) begin
          ds_status_q <= 1'b1;
        end
      end
      downshift_q <= ds_status_q;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence ext_write_off_page;
    mgmt_we && !page1 && mgmt_addr == `ADDR_EXT_MODE;
  endsequence

  page_gate_a: assert property (
      ext_write_off_page |=> $stable(em_q))
    else $error("extended register changed while page one was not selected");
  ind_mode_a: assert property (wr_em |=> ##1
      indicator_output_b_ext_q == $past(mgmt_wdata[13], 2))
    else $error("indicator b mode does not follow its bit");
  blink_sup_a: assert property ($fell(chip_hold_mode)
      && !em_q[11] |=> !indicator_blink_q)
    else $error("blink not suppressed after hold release");
  flf_pin_a: assert property (
      ##1 flf_pin_en_q == $past(em_q[4]))
    else $error("fast link failure enable mismatch");
  xover_a: assert property (em_q[3:2] == 2'h3
      |=> crossed_wiring_q && !auto_xover_q)
    else $error("forced crossed wiring not applied");
  rsvd_zero_a: assert property (mgmt_re && page1
      && mgmt_addr == `ADDR_EXT_MODE |=> mgmt_rvalid_q
      && (mgmt_rdata_q & ~`EM_WMASK) == 16'h0000)
    else $error("reserved bits of register 19 read nonzero");
  media_rd_a: assert property (mgmt_re && page1
      && mgmt_addr == `ADDR_PWR_DOWN && copper_selected
      |=> mgmt_rdata_q[7:6] == 2'h1)
    else $error("media status not reporting copper");
  inl_gate_a: assert property (mgmt_re && page1 && !ic_q[10]
      && mgmt_addr == `ADDR_INL_CRC |=> mgmt_rdata_q[9:8] == 2'h0)
    else $error("detection status visible while detection disabled");
  crc_clr_a: assert property (
      rd_crc && !crc_error |=> crc_count == '0)
    else $error("error counter not cleared by read");
  ds_set_a: assert property (pd_q[4]
      && fail_cnt_q >= ds_limit(pd_q[3:2]) |=> ##1 downshift_q)
    else $error("downshift not flagged after the selected failures");
  sleep_ent_a: assert property (
      ps_q == PS_SLEEP |-> power_save_sleep_q)
    else $error("sleep state without sleep output");
endmodule
`default_nettype wire

/* design/phy_ext_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the
//          extended page 1 control registers.
// Assumes: 50 MHz core clock; 16-bit management register words.
// Notes:   Definitions only.
`ifndef PHY_EXT_MAP_SVH
`define PHY_EXT_MAP_SVH

// ****************************************************************
// Register addresses and page selector
// ****************************************************************
`define ADDR_PAGE_SEL 5'h1F
`define ADDR_EXT_MODE 5'h13
`define ADDR_PWR_DOWN 5'h14
`define ADDR_INL_CRC 5'h17
`define PAGE_MAIN 16'h0000
`define PAGE_EXT1 16'h0001

// ****************************************************************
// Field positions
// ****************************************************************
`define EM_IND_B_EXT 13
`define EM_IND_A_EXT 12
`define EM_BLINK 11
`define EM_FLF 4
`define EM_XOVER_HI 3
`define EM_XOVER_LO 2
`define PD_CEXT_DIS 15
`define PD_SLEEP_HI 14
`define PD_SLEEP_LO 13
`define PD_WAKE_HI 12
`define PD_WAKE_LO 11
`define PD_SLOW_MC 10
`define PD_MEDIA_HI 7
`define PD_MEDIA_LO 6
`define PD_NO_PRE 5
`define PD_DS_EN 4
`define PD_DS_CNT_HI 3
`define PD_DS_CNT_LO 2
`define PD_DS_STAT 1
`define IC_ADDR_HI 15
`define IC_ADDR_LO 11
`define IC_INL_EN 10
`define IC_INL_HI 9
`define IC_INL_LO 8

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define EM_WMASK 16'h381C
`define PD_WMASK 16'hFC3C
`define IC_WMASK 16'h0400
`define EM_RESET 16'h0010
`define PD_RESET 16'hA004
`define IC_RESET 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ 50000000
`define SLEEP_UNIT_S 1
`define WAKE_0_MS 160
`define WAKE_1_MS 400
`define WAKE_2_MS 800
`define WAKE_3_MS 2000
`define SLEEP_UNIT_CYC (`SLEEP_UNIT_S * `CLK_HZ)
`define WAKE_0_CYC (`WAKE_0_MS * (`CLK_HZ / 1000))
`define WAKE_1_CYC (`WAKE_1_MS * (`CLK_HZ / 1000))
`define WAKE_2_CYC (`WAKE_2_MS * (`CLK_HZ / 1000))
`define WAKE_3_CYC (`WAKE_3_MS * (`CLK_HZ / 1000))

`endif

/* design/phy_ext_pkg.sv */
// Purpose: Types shared by the extended page 1 register bank.
// Assumes: Nothing beyond the register map header.
// Notes:   Power-save sequencer states.
package phy_ext_pkg;
  typedef enum logic [0:0] {
    PS_AWAKE,
    PS_SLEEP
  } ps_state_e;
  typedef logic [15:0] reg_word_t;
endpackage

/* design/crc_err_counter.sv */
// Purpose: Error event counter that clears itself when software reads it.
// Assumes: inc and clr are one-cycle pulses on the core clock.
// Notes:   Saturates at all ones instead of wrapping.
`timescale 1ns/1ns
`default_nettype none
module crc_err_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic inc,
  input wire logic clr,
  output logic [WIDTH-1:0] count_q
);
  if (WIDTH < 1) begin : g_chk
    $error("crc_err_counter: WIDTH must be at least one");
  end

  // A read clear and an error in the same cycle leave a count of one, so
  // the new error is never lost.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (clr) begin
      count_q <= inc ? WIDTH'(1) : '0;
    end else if (inc && count_q != {WIDTH{1'b1}}) begin
      count_q <= count_q + WIDTH'(1);
    end
  end
endmodule
`default_nettype wire

/* verif/mgmt_host_model.sv */
// Purpose: Station management controller model for the register port.
// Assumes: One access per task call; strobes launched after a rising edge.
// Notes:   Address and data show inverted values between accesses.
`include "phy_ext_map.svh"
`timescale 1ns/1ns
`default_nettype none
module mgmt_host_model (
  input wire logic clock,
  output logic [4:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  output logic mgmt_we,
  output logic mgmt_re,
  input wire logic [15:0] mgmt_rdata_q,
  input wire logic mgmt_rvalid_q
);
  // Idle port at time zero.
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wdata = 16'h0000;
    mgmt_we = 1'b0;
    mgmt_re = 1'b0;
  end

  // One write, strobe up for exactly one taking edge.
  // Stale address and data are inverted so nothing leans on old values.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_we <= 1'b1;
    @(posedge clock);
    mgmt_we <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask

  // One read; the answer is caught in the cycle after the taking edge.
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clock);
    mgmt_addr <= a;
    mgmt_re <= 1'b1;
    @(posedge clock);
    mgmt_re <= 1'b0;
    mgmt_addr <= ~a;
    #1;
    v = mgmt_rvalid_q;
    d = mgmt_rdata_q;
  endtask

  // The host selects a page before touching the extended registers.
  task automatic sel_page(input logic [15:0] p);
    wr(`ADDR_PAGE_SEL, p);
  endtask
endmodule
`default_nettype wire

/* verif/phy_extended_mode_control_regs_tb_top.sv */
// Purpose: Self-checking bench for the extended page 1 register bank.
// Assumes: Timer parameters shrunk to a 20-cycle second, wake 4/6/8/10.
// Notes:   A reference model of the three registers predicts every read.
`include "phy_ext_map.svh"
`timescale 1ns/1ns
`default_nettype none
module phy_extended_mode_control_regs_tb_top;
  import phy_ext_pkg::*;
  logic clock, rstn, mgmt_we, mgmt_re, mgmt_rvalid_q, chip_hold_mode;
  logic copper_selected, link_idle, link_up, giga_neg_fail, crc_error;
  logic [4:0] mgmt_addr, phy_addr_strap;
  logic [15:0] mgmt_wdata, mgmt_rdata_q;
  logic [1:0] inline_power_found;
  logic ind_a, ind_b, blink, flf, auto_x, crossed, cext, slow, nopre;
  logic sleep, probe, dshift, det_en;
  int em, pd, ic, page, crc_m, ds_m, n_mismatch, checks_done, cycles;

  phy_ext_regs #(.SLEEP_UNIT_CYC(20), .WAKE_0_CYC(4), .WAKE_1_CYC(6),
    .WAKE_2_CYC(8), .WAKE_3_CYC(10)) u_phy_ext_regs (
    .clock(clock), .rstn(rstn), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_we(mgmt_we), .mgmt_re(mgmt_re),
    .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q),
    .chip_hold_mode(chip_hold_mode), .phy_addr_strap(phy_addr_strap),
    .copper_selected(copper_selected), .link_idle(link_idle),
    .link_up(link_up), .giga_neg_fail(giga_neg_fail),
    .inline_power_found(inline_power_found), .crc_error(crc_error),
    .indicator_output_a_ext_q(ind_a), .indicator_output_b_ext_q(ind_b),
    .indicator_blink_q(blink), .flf_pin_en_q(flf), .auto_xover_q(auto_x),
    .crossed_wiring_q(crossed), .carrier_ext_dis_q(cext),
    .slow_mgmt_clock_q(slow), .rx_no_preamble_q(nopre),
    .power_save_sleep_q(sleep), .wake_probe_q(probe),
    .downshift_q(dshift), .inline_power_det_en_q(det_en));

  mgmt_host_model u_mgmt_host_model (.clock(clock), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_we(mgmt_we), .mgmt_re(mgmt_re),
    .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q));

  // ****************************************************************
  // Clock, watchdog and reporting
  // ****************************************************************
  // Free-running 50 MHz core clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // ****************************************************************
  // Reference model and access tasks
  // ****************************************************************
  // Read value predicted from the model state and the status inputs.
  function automatic logic [15:0] exp_rd(input int a);
    logic [15:0] r;
    r = 16'h0000;
    if (a == 31)
      r = page[15:0];
    else if (page == 1 && a == 19)
      r = em[15:0];
    else if (page == 1 && a == 20)
      r = pd[15:0] | {8'h00, 1'b0, copper_selected, 4'h0, ds_m[0], 1'b0};
    else if (page == 1 && a == 23)
      r = {phy_addr_strap, ic[10], ic[10] ? inline_power_found : 2'b00,
           crc_m[7:0]};
    return r;
  endfunction

  task automatic wr(input int a, input logic [15:0] d);
    u_mgmt_host_model.wr(a[4:0], d);
    if (a == 31)
      page = d;
    else if (page == 1 && a == 19)
      em = d & `EM_WMASK;
    else if (page == 1 && a == 20) begin
      pd = d & `PD_WMASK;
      if (d[4] == 1'b0)
        ds_m = 0;
    end
    else if (page == 1 && a == 23)
      ic = d & `IC_WMASK;
  endtask

  // Reading the error counter clears it, so the model follows suit.
  task automatic rchk(input int a);
    logic [15:0] d, e;
    logic v;
    e = exp_rd(a);
    u_mgmt_host_model.rd(a[4:0], d, v);
    chk({15'h0000, v}, 16'h0001, "read valid");
    chk(d, e, "read data");
    if (a == 23 && page == 1)
      crc_m = 0;
  endtask

  // Compares the nine control-bit mode outputs with the model's register bits; blink, sleep, wake probe and downshift are not compared.
  task automatic outs();
    logic [8:0] e, g;
    repeat (2) @(posedge clock);
    #1;
    e = {em[13], em[12], em[4], ~em[3], em[3] & em[2], pd[15], pd[10],
         pd[5], ic[10]};
    g = {ind_b, ind_a, flf, auto_x, crossed, cext, slow, nopre, det_en};
    chk({7'h00, g}, {7'h00, e}, "mode outputs");
  endtask

  // One-cycle event pulse with an idle cycle after it.
  task automatic pulse(input int crc);
    if (crc != 0)
      crc_error <= 1'b1;
    else
      giga_neg_fail <= 1'b1;
    @(posedge clock);
    crc_error <= 1'b0;
    giga_neg_fail <= 1'b0;
    @(posedge clock);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int n, k, lim;
    void'($urandom(73));
    rstn = 1'b0;
    {chip_hold_mode, link_idle, link_up, giga_neg_fail, crc_error} = 5'h00;
    copper_selected = 1'b1;
    inline_power_found = 2'b00;
    phy_addr_strap = 5'($urandom);
    em = `EM_RESET;
    pd = 16'hA004;
    ic = 0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    outs();
    rchk(19);
    wr(19, 16'h0000);
    u_mgmt_host_model.sel_page(16'h0001);
    page = 1;
    rchk(19);
    rchk(20);
    rchk(23);
    rchk(5);
    for (k = 0; k < 6; k++) begin
      copper_selected <= k[0];
      inline_power_found <= 2'($urandom_range(0, 2));
      for (n = 0; n < 3; n++) begin
        lim = (n == 0) ? 19 : (n == 1) ? 20 : 23;
        wr(lim, 16'($urandom));
        outs();
        rchk(lim);
      end
    end
    for (n = 0; n < 3; n++) begin
      inline_power_found <= 2'(n);
      wr(23, 16'h0400);
      rchk(23);
    end
    for (n = 0; n < 4; n++) begin
      wr(19, 16'(n << 2));
      outs();
    end
    wr(31, 16'h0002);
    rchk(19);
    wr(31, 16'h0001);
    for (n = 0; n < 2; n++) begin
      wr(19, 16'(n << 11));
      chip_hold_mode <= 1'b1;
      repeat (3) @(posedge clock);
      chip_hold_mode <= 1'b0;
      k = 0;
      repeat (6) begin
        @(posedge clock);
        #1;
        k += int'(blink === 1'b1);
      end
      chk(16'(k), 16'(n), "blink pulses");
    end
    for (n = 0; n < 4; n++) begin
      link_up <= 1'b1;
      @(posedge clock);
      link_up <= 1'b0;
      wr(20, 16'h0000);
      repeat (5) pulse(0);
      wr(20, 16'(16'h0010 | (n << 2)));
      repeat (n + 1) pulse(0);
      repeat (3) @(posedge clock);
      rchk(20);
      pulse(0);
      repeat (3) @(posedge clock);
      ds_m = 1;
      rchk(20);
      chk({15'h0000, dshift}, 16'h0001, "downshift out");
    end
    k = $urandom_range(1, 20);
    repeat (k) pulse(1);
    crc_m = k;
    rchk(23);
    rchk(23);
    repeat (300) pulse(1);
    crc_m = 255;
    rchk(23);
    for (n = 0; n < 4; n++) begin
      wr(20, 16'((n << 13) | (n << 11)));
      link_idle <= 1'b1;
      lim = (n + 1) * 20;
      k = 0;
      while (sleep !== 1'b1 && k < 200) begin
        @(posedge clock);
        #1;
        k++;
      end
      chk({15'h0000, k >= lim && k <= lim + 3}, 16'h0001,
          "sleep delay");
      k = 0;
      repeat (60) begin
        @(posedge clock);
        #1;
        k += int'(probe === 1'b1);
      end
      lim = 60 / (4 + 2 * n);
      chk({15'h0000, k >= lim - 1 && k <= lim + 1}, 16'h0001,
          "wake probes");
      @(posedge clock);
      link_idle <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk({15'h0000, sleep}, 16'h0000, "wake on energy");
    end
    // A reset in mid-run must restore every default and catch new straps.
    phy_addr_strap <= 5'($urandom);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    em = `EM_RESET;
    pd = 16'hA004;
    ic = 0;
    page = 0;
    crc_m = 0;
    ds_m = 0;
    repeat (2) @(posedge clock);
    outs();
    rchk(19);
    wr(31, 16'h0001);
    rchk(20);
    rchk(23);
    summarize();
  end
endmodule
`default_nettype wire
